//--- logic/stc_consts.svh
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// control bus device addresses
`define STC_ADDR_CS 8'he9
`define STC_ADDR_IO 8'he8
// fixed upper six header bits of an i/o setting write
`define STC_IO_HDR_TAG 6'h2c
// header field positions
`define STC_HDR_CHIP_LSB 0
`define STC_HDR_LEN_LSB 4
`define STC_HDR_BITS 8
// frame sizes
`define STC_CS_BITS 48
`define STC_FRAME_BITS 56
`define STC_IO_FRAME_BITS 6'd16
`define STC_LEN_MAX 3'd5
// i/o setting bit positions inside the data byte
`define STC_IO_FMT 0
`define STC_IO_LRP 1
`define STC_IO_SRC 2
`define STC_IO_MUTE 3
`define STC_IO_MODE_LSB 4
`define STC_IO_RATIO 7
// mode field codes
`define STC_MODE_STEREO 2'b00
`define STC_MODE_LEFT 2'b01
`define STC_MODE_RIGHT 2'b10
// reset values
`define STC_IO_RESET 8'h00
`define STC_CS_RESET 48'h0
// host timing: i_clock cycles per half serial clock, idle gap ticks
`define STC_CL_HALF 3'd2
`define STC_GAP_TICKS 6'd8
// host register byte offsets
`define STC_REG_CTRL 4'h0
`define STC_REG_IO 4'h4
`define STC_REG_CS_LO 4'h8
`define STC_REG_CS_HI 4'hc
// host control register fields
`define STC_CTRL_GO_CS 0
`define STC_CTRL_GO_IO 1
`define STC_CTRL_CHIP_LSB 4
`define STC_CTRL_LEN_LSB 8
`define STC_CTRL_BUSY 16

`endif

//--- logic/stc_pkg.sv
`include "stc_consts.svh"

package stc_pkg;

	typedef enum logic [2:0] {
		STC_IDLE = 3'b000,
		STC_ADDR = 3'b001,
		STC_CE_UP = 3'b011,
		STC_DATA = 3'b010,
		STC_CE_DN = 3'b110,
		STC_GAP = 3'b111
	} stc_host_fsm_t;

	typedef struct packed {
		logic ce_s1;
		logic ce_s2;
		logic ce_s3;
		logic lr_s1;
		logic lr_s2;
		logic txd_s1;
		logic txd_s2;
		logic aux_s1;
		logic aux_s2;
		logic [7:0] io_cfg;
		logic [47:0] staging;
		logic [47:0] active;
		logic pending;
		logic frame_error;
		logic modulated_out;
		logic mod_data;
		logic left_phase;
		logic fmt_lj;
		logic mclk_128;
		logic [1:0] chan_en;
	} stc_dev_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [55:0] bits;
		logic [5:0] count;
	} stc_rx_state_t;

	typedef struct packed {
		stc_host_fsm_t fsm;
		logic [2:0] half_cnt;
		logic [5:0] bit_idx;
		logic [5:0] last_bit;
		logic [7:0] addr;
		logic [55:0] frame;
		logic ce;
		logic cl;
		logic di;
		logic [1:0] chip;
		logic [2:0] len;
		logic [7:0] io;
		logic [47:0] cs;
		logic [31:0] readdata;
		logic waitrequest;
	} stc_host_state_t;

	// data bits carried for a length code
	function automatic logic [5:0] stc_len_bits(input logic [2:0] code);
		stc_len_bits = {code + 3'd1, 3'b000};
	endfunction

endpackage

//--- logic/stc_link_if.sv
interface stc_link_if;
	logic ce;
	logic serial_clock_line;
	logic di;
	modport dev (input ce, input serial_clock_line, input di);
	modport host (output ce, output serial_clock_line, output di);
endinterface

//--- logic/stc_link_rx.sv
`include "stc_consts.svh"

module stc_link_rx import stc_pkg::*; (
	input wire logic i_serial_clock_line, // link clock, data sampled on rise
	input wire logic i_ce, // chip enable from host
	input wire logic i_di, // serial data
	output logic [7:0] o_addr, // last device address byte
	output logic [55:0] o_bits, // frame bits, index is bit position
	output logic [5:0] o_count // bits clocked with chip enable high
);
	stc_rx_state_t st;
	stc_rx_state_t next_st;
	logic in_frame;

	////////////////////////////////////////////////////////////////
	// frame marker, ended by the frame's own enable falling
	always_ff @(posedge i_serial_clock_line or negedge i_ce) begin
		if (!i_ce) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	// address shifts with enable low, frame bits stored by position
	always_comb begin
		next_st = st;
		if (!i_ce) begin
			next_st.addr = {i_di, st.addr[7:1]};
		end else if (!in_frame) begin
			next_st.bits[0] = i_di;
			next_st.count = 6'd1;
		end else begin
			if (st.count < 6'd56) begin
				next_st.bits[st.count] = i_di;
			end
			if (st.count != 6'd63) begin
				next_st.count = st.count + 6'd1;
			end
		end
	end

	// no reset: clock only runs during transfers, all fields set before use
	always_ff @(posedge i_serial_clock_line) begin
		st <= next_st;
	end

	assign o_addr = st.addr;
	assign o_bits = st.bits;
	assign o_count = st.count;
endmodule

//--- logic/stc_device.sv
`include "stc_consts.svh"

module stc_device import stc_pkg::*; #(
	parameter logic [1:0] CHIP_ADDR = 2'b00 // this device's chip address
) (
	input wire logic i_clock, // core clock
	input wire logic i_rst, // synchronous reset, active high
	stc_link_if.dev link, // control bus from host
	input wire logic i_block_start, // block-start preamble pulse from modulator
	input wire logic i_modulated, // biphase stream from modulator
	input wire logic i_tx_data_in, // dedicated transmit data pin
	input wire logic i_aux_serial_audio_in, // general serial audio pin
	input wire logic i_tx_lr_clock_in, // transmit lr clock pin
	output logic o_modulated_out, // transmit output
	output logic o_mod_data, // selected audio data to modulator
	output logic o_left_phase, // high while lr clock marks left
	output logic [1:0] o_chan_en, // bit0 left, bit1 right sent
	output logic o_tx_format_sel, // high selects left-justified input
	output logic o_tx_mclk_ratio, // high means 128fs master clock
	output logic [47:0] o_cs_bits, // status bits sent in both subframes
	output logic o_cs_pending, // loaded bits wait for block start
	output logic o_frame_error // one-cycle pulse, frame rejected
);
	stc_dev_state_t st;
	stc_dev_state_t next_st;
	logic [7:0] rx_addr;
	logic [55:0] rx_bits;
	logic [5:0] rx_count;

	////////////////////////////////////////////////////////////////
	// link clock domain capture
	// the core reads these bits only after the enable fall has passed
	// its syncs; the host has stopped the link clock by then, so the
	// word is quiet while the core samples it
	stc_link_rx stc_link_rx_inst (
		.i_serial_clock_line(link.serial_clock_line),
		.i_ce(link.ce),
		.i_di(link.di),
		.o_addr(rx_addr),
		.o_bits(rx_bits),
		.o_count(rx_count)
	);

	////////////////////////////////////////////////////////////////
	// frame decode helpers
	logic frame_end;
	logic [7:0] hdr;
	logic [2:0] len_code;
	logic [5:0] len_bits;
	logic chip_ok;
	logic cs_ok;
	logic io_ok;

	// enable fall seen after two sync stages; link data is quiet then
	assign frame_end = st.ce_s3 & ~st.ce_s2;
	assign hdr = rx_bits[7:0];
	assign len_code = hdr[`STC_HDR_LEN_LSB +: 3];
	// reserved code 6 gives 56 bits and code 7 wraps to 0, cs_ok refuses them anyway
	assign len_bits = stc_len_bits(len_code);
	assign chip_ok = (hdr[`STC_HDR_CHIP_LSB +: 2] == CHIP_ADDR);

	// a short or long frame leaves staging untouched, never half loaded
	// status write needs its own address
	// exact count of header plus data clocks
	assign cs_ok = (rx_addr == `STC_ADDR_CS) && chip_ok && (len_code <= `STC_LEN_MAX) &&
		(rx_count == 6'(`STC_HDR_BITS) + len_bits);

	// the tag stops a stray status header landing in the i/o byte
	// i/o setting frame: fixed tag, sixteen clocks
	assign io_ok = (rx_addr == `STC_ADDR_IO) && chip_ok &&
		(hdr[7:2] == `STC_IO_HDR_TAG) && (rx_count == `STC_IO_FRAME_BITS);

	////////////////////////////////////////////////////////////////
	// channel enables for a mode code, bit0 left, bit1 right
	function automatic logic [1:0] stc_chan_enable(input logic [1:0] mode);
		case (mode)
			`STC_MODE_STEREO: begin
				stc_chan_enable = 2'b11;
			end
			`STC_MODE_LEFT: begin
				stc_chan_enable = 2'b01;
			end
			`STC_MODE_RIGHT: begin
				stc_chan_enable = 2'b10;
			end
			default: begin
				// reserved code: neither channel goes out
				stc_chan_enable = 2'b00;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// next state
	// one process for all core state, reset last so it overrides
	always_comb begin
		logic [5:0] idx;
		idx = 6'd0;
		next_st = st;
		next_st.frame_error = 1'b0;

		// two-stage syncs for pins and link enable
		// lr, data and aux pins run on audio clocks, not the core clock
		next_st.ce_s1 = link.ce;
		next_st.ce_s2 = st.ce_s1;
		next_st.ce_s3 = st.ce_s2;
		next_st.lr_s1 = i_tx_lr_clock_in;
		next_st.lr_s2 = st.lr_s1;
		next_st.txd_s1 = i_tx_data_in;
		next_st.txd_s2 = st.txd_s1;
		next_st.aux_s1 = i_aux_serial_audio_in;
		next_st.aux_s2 = st.aux_s1;

		// frames for other addresses belong to other blocks, ignored quietly
		if (frame_end) begin
			if (cs_ok) begin
				// merge only the written bytes into staging
				for (int i = 0; i < `STC_CS_BITS; i++) begin
					idx = 6'(i);
					// frame bit 8+i is status bit i
					// bits past length keep old value
					if (idx < len_bits) begin
						next_st.staging[i] = rx_bits[`STC_HDR_BITS + i];
					end
				end
			end else if (io_ok) begin
				next_st.io_cfg = rx_bits[15:8];
			end else if (rx_addr == `STC_ADDR_CS || rx_addr == `STC_ADDR_IO) begin
				next_st.frame_error = 1'b1;
			end
		end

		// a commit and a block start in one cycle: the old staging goes
		// out now and the new bits wait for the following block
		// load waits for block start; new write wins over apply
		if (frame_end && cs_ok) begin
			next_st.pending = 1'b1;
		end else if (i_block_start) begin
			next_st.pending = 1'b0;
		end
		// pending drops once a block start has taken the bits
		// apply staged bits at block start
		if (i_block_start && st.pending) begin
			next_st.active = st.staging;
		end

		next_st.fmt_lj = st.io_cfg[`STC_IO_FMT];
		next_st.left_phase = ~(st.lr_s2 ^ st.io_cfg[`STC_IO_LRP]);
		next_st.mod_data = st.io_cfg[`STC_IO_SRC] ? st.aux_s2 : st.txd_s2;
		// registered after the mux, so muting never glitches the pin
		// mute holds output low
		next_st.modulated_out = st.io_cfg[`STC_IO_MUTE] ? 1'b0 : i_modulated;
		next_st.mclk_128 = st.io_cfg[`STC_IO_RATIO];

		// channel enables, reserved code sends nothing
		next_st.chan_en = stc_chan_enable(st.io_cfg[`STC_IO_MODE_LSB +: 2]);

		// reset: config bits to their defaults, stereo, status cleared
		if (i_rst) begin
			next_st = '0;
			next_st.io_cfg = `STC_IO_RESET;
			next_st.staging = `STC_CS_RESET;
			next_st.active = `STC_CS_RESET;
			next_st.chan_en = stc_chan_enable(`STC_MODE_STEREO);
		end
	end

	////////////////////////////////////////////////////////////////
	// state register, sync reset handled in the next-state process
	always_ff @(posedge i_clock) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from state
	// config outputs lag the i/o register by one cycle
	assign o_modulated_out = st.modulated_out;
	assign o_mod_data = st.mod_data;
	assign o_left_phase = st.left_phase;
	assign o_chan_en = st.chan_en;
	assign o_tx_format_sel = st.fmt_lj;
	assign o_tx_mclk_ratio = st.mclk_128;
	assign o_cs_bits = st.active;
	assign o_cs_pending = st.pending;
	assign o_frame_error = st.frame_error;
endmodule

//--- logic/stc_host.sv
`include "stc_consts.svh"

module stc_host import stc_pkg::*; (
	input wire logic i_clock, // host clock
	input wire logic i_rst, // synchronous reset, active high
	stc_link_if.host link, // control bus to device
	input wire logic [3:0] i_address, // avalon byte address
	input wire logic i_read, // avalon read
	input wire logic i_write, // avalon write
	input wire logic [31:0] i_writedata, // avalon write data
	output logic [31:0] o_readdata, // avalon read data
	output logic o_waitrequest // avalon wait, low for one cycle to accept
);
	stc_host_state_t st;
	stc_host_state_t next_st;
	logic tick;
	logic accept;
	logic busy;

	assign tick = (st.half_cnt == `STC_CL_HALF - 3'd1);
	assign accept = (i_read | i_write) & st.waitrequest;
	assign busy = (st.fsm != STC_IDLE);

	////////////////////////////////////////////////////////////////
	// register access, frame engine
	always_comb begin
		next_st = st;
		next_st.waitrequest = ~accept;
		next_st.half_cnt = tick ? 3'd0 : st.half_cnt + 3'd1;

		// read data prepared on the cycle wait drops
		if (accept && i_read) begin
			case (i_address)
				`STC_REG_CTRL: next_st.readdata = 32'({busy, 5'h00, st.len, 2'b00, st.chip, 4'h0});
				`STC_REG_IO: next_st.readdata = {24'h0, st.io};
				`STC_REG_CS_LO: next_st.readdata = st.cs[31:0];
				`STC_REG_CS_HI: next_st.readdata = {16'h0, st.cs[47:32]};
				default: next_st.readdata = 32'h0;
			endcase
		end

		if (!st.waitrequest && i_write) begin
			case (i_address)
				`STC_REG_CTRL: begin
					next_st.chip = i_writedata[`STC_CTRL_CHIP_LSB +: 2];
					next_st.len = i_writedata[`STC_CTRL_LEN_LSB +: 3];
				end
				`STC_REG_IO: next_st.io = i_writedata[7:0];
				`STC_REG_CS_LO: next_st.cs[31:0] = i_writedata;
				`STC_REG_CS_HI: next_st.cs[47:32] = i_writedata[15:0];
				default: begin
				end
			endcase
		end

		case (st.fsm)
			STC_IDLE: begin
				// reserved length codes never start a status frame
				if (!st.waitrequest && i_write && i_address == `STC_REG_CTRL &&
					((i_writedata[`STC_CTRL_GO_CS] &&
					i_writedata[`STC_CTRL_LEN_LSB +: 3] <= `STC_LEN_MAX) ||
					(!i_writedata[`STC_CTRL_GO_CS] && i_writedata[`STC_CTRL_GO_IO]))) begin
					next_st.chip = i_writedata[`STC_CTRL_CHIP_LSB +: 2];
					next_st.len = i_writedata[`STC_CTRL_LEN_LSB +: 3];
					next_st.fsm = STC_ADDR;
					next_st.bit_idx = 6'd0;
					next_st.half_cnt = 3'd0;
					next_st.cl = 1'b0;
					if (i_writedata[`STC_CTRL_GO_CS]) begin
						next_st.addr = `STC_ADDR_CS;
						// chip address low, reserved bits zero
						next_st.frame = {st.cs, 1'b0, i_writedata[`STC_CTRL_LEN_LSB +: 3], 2'b00,
							i_writedata[`STC_CTRL_CHIP_LSB +: 2]};
						next_st.last_bit = 6'(`STC_HDR_BITS) +
							stc_len_bits(i_writedata[`STC_CTRL_LEN_LSB +: 3]) - 6'd1;
					end else begin
						next_st.addr = `STC_ADDR_IO;
						next_st.frame = {40'h0, st.io, `STC_IO_HDR_TAG,
							i_writedata[`STC_CTRL_CHIP_LSB +: 2]};
						next_st.last_bit = `STC_IO_FRAME_BITS - 6'd1;
					end
					next_st.di = next_st.addr[0];
				end
			end
			STC_ADDR: begin
				if (tick) begin
					next_st.cl = ~st.cl;
					if (st.cl) begin
						if (st.bit_idx == 6'd7) begin
							next_st.fsm = STC_CE_UP;
						end else begin
							next_st.bit_idx = st.bit_idx + 6'd1;
							next_st.di = st.addr[3'(st.bit_idx + 6'd1)];
						end
					end
				end
			end
			STC_CE_UP: begin
				if (tick) begin
					next_st.ce = 1'b1;
					next_st.bit_idx = 6'd0;
					next_st.di = st.frame[0];
					next_st.fsm = STC_DATA;
				end
			end
			STC_DATA: begin
				if (tick) begin
					next_st.cl = ~st.cl;
					if (st.cl) begin
						if (st.bit_idx == st.last_bit) begin
							next_st.fsm = STC_CE_DN;
						end else begin
							next_st.bit_idx = st.bit_idx + 6'd1;
							next_st.di = st.frame[st.bit_idx + 6'd1];
						end
					end
				end
			end
			STC_CE_DN: begin
				if (tick) begin
					next_st.ce = 1'b0;
					next_st.di = 1'b0;
					next_st.bit_idx = 6'd0;
					next_st.fsm = STC_GAP;
				end
			end
			STC_GAP: begin
				if (tick) begin
					next_st.bit_idx = st.bit_idx + 6'd1;
					if (st.bit_idx == `STC_GAP_TICKS) begin
						next_st.fsm = STC_IDLE;
					end
				end
			end
			default: begin
				next_st.fsm = STC_IDLE;
			end
		endcase

		if (i_rst) begin
			next_st = '0;
			next_st.fsm = STC_IDLE;
			next_st.io = `STC_IO_RESET;
			next_st.cs = `STC_CS_RESET;
			next_st.waitrequest = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign link.ce = st.ce;
	assign link.serial_clock_line = st.cl;
	assign link.di = st.di;
	assign o_readdata = st.readdata;
	assign o_waitrequest = st.waitrequest;
endmodule

//--- testbench/stc_link_checker.sv
////////////////////////////////////////////////////////////////
// link checker: watches the control bus between host and device
module stc_link_checker (
	input wire logic i_clock, // core clock
	input wire logic i_rst, // sync reset, active high
	input wire logic ce, // chip enable
	input wire logic serial_clock_line, // link clock
	input wire logic di // serial data
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic cl_d;
		logic ce_d;
		logic [3:0] acnt;
		logic [7:0] addr;
		logic [6:0] cnt;
		logic [7:0] hdr;
	} stc_chk_state_t;
	stc_chk_state_t s;
	stc_chk_state_t next_s;
	logic rise;
	assign rise = serial_clock_line && !s.cl_d;
	// track address byte, header byte and frame clock count
	always_comb begin
		next_s = s;
		next_s.cl_d = serial_clock_line;
		next_s.ce_d = ce;
		if (ce && !s.ce_d)
			next_s.cnt = 7'd0;
		if (!ce && s.ce_d)
			next_s.acnt = 4'd0;
		if (rise && ce) begin
			if (s.cnt < 7'd8)
				next_s.hdr[s.cnt[2:0]] = di;
			next_s.cnt = s.cnt + 7'd1;
		end
		if (rise && !ce) begin
			next_s.addr = {di, s.addr[7:1]};
			if (s.acnt != 4'hf)
				next_s.acnt = s.acnt + 4'd1;
		end
	end
	// helper state register
	always_ff @(posedge i_clock) begin
		if (i_rst)
			s <= '0;
		else
			s <= next_s;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	property p_cl_pulse;
		$rose(serial_clock_line) |-> serial_clock_line [*2] ##1 !serial_clock_line;
	endproperty
	a_cl_pulse: assert property (p_cl_pulse) else $error("link clock pulse width wrong");
	property p_di_hold;
		serial_clock_line && $past(serial_clock_line) |-> $stable(di);
	endproperty
	a_di_hold: assert property (p_di_hold) else $error("data moved while clock high");
	property p_ce_edge;
		$changed(ce) |-> !serial_clock_line;
	endproperty
	a_ce_edge: assert property (p_ce_edge) else $error("chip enable moved while clock high");
	property p_addr_count;
		$rose(ce) |-> s.acnt == 4'd8;
	endproperty
	a_addr_count: assert property (p_addr_count) else $error("address byte not eight clocks");
	property p_addr_value;
		$rose(ce) |-> s.addr inside {8'he9, 8'he8};
	endproperty
	a_addr_value: assert property (p_addr_value) else $error("frame without device address");
	property p_hdr_reserved;
		$fell(ce) && s.addr == 8'he9 |-> s.hdr[2] == 1'b0 && s.hdr[3] == 1'b0 && s.hdr[7] == 1'b0;
	endproperty
	a_hdr_reserved: assert property (p_hdr_reserved) else $error("reserved header bit set");
	property p_len_match;
		$fell(ce) && s.addr == 8'he9 |-> s.hdr[6:4] <= 3'd5 && s.cnt == 7'd16 + {1'b0, s.hdr[6:4], 3'b000};
	endproperty
	a_len_match: assert property (p_len_match) else $error("clock count differs from length");
	property p_gap;
		$fell(ce) |-> !ce [*4];
	endproperty
	a_gap: assert property (p_gap) else $error("chip enable rose too soon");
endmodule

//--- testbench/spdif_tx_config_and_cs_write_tb.sv
`include "stc_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
	$display("[FAIL] %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module spdif_tx_config_and_cs_write_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock, i_rst, i_read, i_write, i_block_start, i_modulated, i_tx_data_in, i_aux, i_lr;
	logic [3:0] i_address;
	logic [31:0] i_writedata, o_readdata, q;
	logic o_waitrequest, o_modulated_out, o_mod_data, o_left_phase, o_tx_format_sel, o_tx_mclk_ratio;
	logic o_cs_pending, o_frame_error;
	logic [1:0] o_chan_en;
	logic [47:0] o_cs_bits;
	int fails = 0;
	int n_tests = 0;
	int n_err = 0;
	stc_link_if link_if();
	stc_host stc_host_inst (.i_clock(i_clock), .i_rst(i_rst), .link(link_if), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest));
	stc_device #(.CHIP_ADDR(2'b00)) stc_device_inst (.i_clock(i_clock), .i_rst(i_rst), .link(link_if),
		.i_block_start(i_block_start), .i_modulated(i_modulated), .i_tx_data_in(i_tx_data_in),
		.i_aux_serial_audio_in(i_aux), .i_tx_lr_clock_in(i_lr), .o_modulated_out(o_modulated_out),
		.o_mod_data(o_mod_data), .o_left_phase(o_left_phase), .o_chan_en(o_chan_en),
		.o_tx_format_sel(o_tx_format_sel), .o_tx_mclk_ratio(o_tx_mclk_ratio), .o_cs_bits(o_cs_bits),
		.o_cs_pending(o_cs_pending), .o_frame_error(o_frame_error));
	stc_link_checker stc_link_checker_inst (.i_clock(i_clock), .i_rst(i_rst), .ce(link_if.ce),
		.serial_clock_line(link_if.serial_clock_line), .di(link_if.di));
	////////////////////////////////////////////////////////////////
	// clock, rejected frame counter, watchdog
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		if (o_frame_error === 1'b1)
			n_err++;
	end
	initial begin
		repeat (60000) @(posedge i_clock);
		fails++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	// avalon master: hold request until waitrequest low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge i_clock);
		i_write <= wr;
		i_read <= !wr;
		i_address <= a;
		i_writedata <= d;
		// ends when waitrequest reads low; no timeout of its own, the watchdog ends a hang
		do begin
			@(posedge i_clock);
		end while (o_waitrequest !== 1'b0);
		r = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask
	// poll until frame sent, then let device settle
	task automatic wait_idle(output logic [31:0] r);
		do begin
			av(1'b0, `STC_REG_CTRL, 32'h0, r);
		end while (r[`STC_CTRL_BUSY] !== 1'b0);
		repeat (8) @(posedge i_clock);
	endtask
	task automatic load_cs(input logic [31:0] lo, input logic [31:0] hi, input logic [2:0] len,
		input logic [1:0] chip);
		av(1'b1, `STC_REG_CS_LO, lo, q);
		av(1'b1, `STC_REG_CS_HI, hi, q);
		av(1'b1, `STC_REG_CTRL, {21'h0, len, 2'b00, chip, 4'h1}, q);
		wait_idle(q);
	endtask
	task automatic block_pulse();
		@(posedge i_clock);
		i_block_start <= 1'b1;
		@(posedge i_clock);
		i_block_start <= 1'b0;
		repeat (2) @(posedge i_clock);
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		repeat (4) @(posedge i_clock);
		`CHK(o_tx_format_sel, 1'b0);
		`CHK(o_left_phase, 1'b1);
		`CHK(o_mod_data, 1'b1);
		`CHK(o_modulated_out, 1'b1);
		`CHK(o_chan_en, 2'b11);
		`CHK(o_tx_mclk_ratio, 1'b0);
		`CHK(o_cs_bits, 48'h0);
		av(1'b0, 4'h2, 32'h0, q);
		`CHK(q, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_io();
		logic [7:0] tab [4];
		logic [7:0] v;
		tab = '{8'h00, 8'h9f, 8'h20, 8'h35};
		for (int i = 0; i < 4; i++) begin
			v = tab[i];
			av(1'b1, `STC_REG_IO, {24'h0, v}, q);
			av(1'b1, `STC_REG_CTRL, 32'h2, q);
			wait_idle(q);
			`CHK(o_tx_format_sel, v[0]);
			`CHK(o_left_phase, !v[1]);
			`CHK(o_mod_data, !v[2]);
			`CHK(o_modulated_out, !v[3]);
			`CHK(o_chan_en, v[5:4] == 2'b00 ? 2'b11 : v[5:4] == 2'b11 ? 2'b00 : v[5:4]);
			`CHK(o_tx_mclk_ratio, v[7]);
			// lr clock high: left phase follows the polarity bit
			i_lr <= 1'b1;
			repeat (4) @(posedge i_clock);
			`CHK(o_left_phase, v[1]);
			i_lr <= 1'b0;
		end
		$display("test io settings done");
	endtask
	task automatic t_cs_full();
		load_cs(32'h89ab_cdef, 32'h0000_4567, 3'd5, 2'b00);
		`CHK(o_cs_pending, 1'b1);
		`CHK(o_cs_bits, 48'h0);
		block_pulse();
		`CHK(o_cs_bits, 48'h4567_89ab_cdef);
		`CHK(o_cs_pending, 1'b0);
		$display("test full status done");
	endtask
	task automatic t_cs_part();
		load_cs(32'hffff_ff11, 32'hffff_ffff, 3'd0, 2'b00);
		block_pulse();
		`CHK(o_cs_bits, 48'h4567_89ab_cd11);
		load_cs(32'h0000_2233, 32'h0, 3'd1, 2'b00);
		block_pulse();
		`CHK(o_cs_bits, 48'h4567_89ab_2233);
		$display("test partial status done");
	endtask
	task automatic t_err();
		int e0;
		e0 = n_err;
		load_cs(32'h0000_00ff, 32'h0, 3'd0, 2'b01);
		`CHK(q, 32'h0000_0010);
		`CHK(n_err, e0 + 1);
		`CHK(o_cs_pending, 1'b0);
		block_pulse();
		`CHK(o_cs_bits, 48'h4567_89ab_2233);
		// reserved length code: host must not start a frame
		av(1'b1, `STC_REG_CTRL, 32'h0000_0601, q);
		av(1'b0, `STC_REG_CTRL, 32'h0, q);
		`CHK(q[`STC_CTRL_BUSY], 1'b0);
		`CHK(n_err, e0 + 1);
		$display("test wrong chip done");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		i_rst = 1'b1;
		{i_read, i_write, i_block_start, i_aux, i_lr} = '0;
		{i_modulated, i_tx_data_in} = 2'b11;
		i_address = 4'h0;
		i_writedata = 32'h0;
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		t_reset();
		t_io();
		t_cs_full();
		t_cs_part();
		t_err();
		test_done();
	end
endmodule
